/* core/spbm_pkg.sv */
// Package for the scan pattern and button mode controller.
// Holds timing counts, register map and shared enumerations.
package spbm_pkg;
   // Clock rate and millisecond tick
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned MS_NS = 1_000_000;
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned TICK_CYCLES = MS_NS / CLK_NS;
   // Times in milliseconds
   localparam int unsigned DEBOUNCE_MS = 20;
   localparam int unsigned DCLICK_MS = 400;
   localparam int unsigned NOSCAN_MS = 5000;
   localparam int unsigned BEEP_MS = 100;
   localparam int unsigned FLASH_MS = 100;
   // Register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] TIME_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   // Configuration field positions
   localparam int unsigned CFG_HOLD_BIT = 0;
   localparam int unsigned CFG_GATE_BIT = 1;
   localparam int unsigned CFG_PRI_LSB = 4;
   localparam int unsigned CFG_SEC_LSB = 6;
   // Reset values: click, gate on, primary omni, secondary single line
   localparam logic [31:0] CFG_RST = 32'h0000_0042;
   localparam logic [15:0] NOSCAN_RST = 16'h1388;
   localparam logic [15:0] DCLICK_RST = 16'h0190;
   // Scan patterns
   typedef enum logic [1:0] {
      SPBM_PAT_OMNI = 2'b00,
      SPBM_PAT_LINE = 2'b01,
      SPBM_PAT_RASTER = 2'b10
   } spbm_pat_t;
   // Pattern mode state
   typedef enum logic [1:0] {
      SPBM_ST_PRI = 2'b00,
      SPBM_ST_SEC = 2'b01,
      SPBM_ST_HREL = 2'b10
   } spbm_state_t;
endpackage

/* core/spbm_btn_if.sv */
// Interface carrying cleaned button events between the filter and the controller.
// Assumes a single clock domain on core_clk.
`timescale 1ns/1ns
interface spbm_btn_if;
   logic level;
   logic press;
   logic release_ev;
   logic dclick;
   logic tick;
   logic [15:0] dclick_ms;
   modport filt (output level, output press, output release_ev, output dclick, output tick,
      input dclick_ms);
   modport ctl (input level, input press, input release_ev, input dclick, input tick,
      output dclick_ms);
endinterface

/* core/spbm_btn_filter.sv */
// Button synchroniser, debouncer, click and double click detector.
// Assumes core_clk at 100 MHz and a raw button pin that is high when pressed.
`timescale 1ns/1ns
module spbm_btn_filter
#(
   parameter int unsigned TICK = spbm_pkg::TICK_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Raw pin
   input wire logic btn_pin,
   // Cleaned events
   spbm_btn_if.filt bi
);
   if (TICK < 2 || TICK > 32'h0002_0000)
      $error("TICK out of range");
   logic s1_r, s2_r, stab_r, dcl_arm_r;
   logic [16:0] tdiv_r;
   logic [7:0] deb_r;
   logic [15:0] gap_r;
   // Two stage synchroniser
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end
      else
      begin
         s1_r <= btn_pin;
         s2_r <= s1_r;
      end
   end
   // Millisecond tick divider
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         tdiv_r <= 17'h00000;
         bi.tick <= 1'b0;
      end
      else
      begin
         bi.tick <= (tdiv_r == 17'(TICK - 1));
         tdiv_r <= (tdiv_r == 17'(TICK - 1)) ? 17'h00000 : tdiv_r + 17'h00001;
      end
   end
   // Debounce: level must hold for the debounce time before it is taken
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         deb_r <= 8'h00;
         stab_r <= 1'b0;
         bi.press <= 1'b0;
         bi.release_ev <= 1'b0;
      end
      else
      begin
         bi.press <= 1'b0;
         bi.release_ev <= 1'b0;
         if (s2_r == stab_r)
            deb_r <= 8'h00;
         else if (bi.tick)
         begin
            if (deb_r == 8'(spbm_pkg::DEBOUNCE_MS - 1))
            begin
               stab_r <= s2_r; // [RL17]
               bi.press <= s2_r;
               bi.release_ev <= ~s2_r;
               deb_r <= 8'h00;
            end
            else
               deb_r <= deb_r + 8'h01;
         end
      end
   end
   assign bi.level = stab_r;
   // Double click: a second release within the interval after a first release
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         dcl_arm_r <= 1'b0;
         gap_r <= 16'h0000;
         bi.dclick <= 1'b0;
      end
      else
      begin
         bi.dclick <= 1'b0;
         if (bi.release_ev)
         begin
            if (dcl_arm_r)
            begin
               bi.dclick <= 1'b1; // [RL17]
               dcl_arm_r <= 1'b0;
            end
            else
            begin
               dcl_arm_r <= 1'b1;
               gap_r <= 16'h0000;
            end
         end
         else if (dcl_arm_r && bi.tick)
         begin
            if (gap_r >= bi.dclick_ms)
               dcl_arm_r <= 1'b0;
            else
               gap_r <= gap_r + 16'h0001;
         end
      end
   end
   debounce_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [RL17]
      bi.press |-> stab_r) else $error("press without stable level");
endmodule

/* core/spbm_ctrl.sv */
// Scan pattern and button mode controller with AHB-Lite registers.
// Assumes a 100 MHz core_clk, a button pin and a decode path that flags reads.
//
// Contract
// RL1 - After reset the primary pattern mode runs until a button event moves it.
// RL2 - A button activation enters the secondary (button) pattern mode.
// RL3 - Secondary mode returns to primary on a double click or a no-scan timeout.
// RL4 - Each mode holds its own choice of omni, single line or raster pattern.
// RL5 - Decode gating applies only while the secondary mode is active.
// RL6 - Four button modes, click or hold with gate on or off; reset is click with gate on.
// RL7 - In click mode a press and release enters the secondary mode.
// RL8 - Click mode with gate on: each further click allows one decode and transmit with a beep.
// RL9 - Click mode with gate off: secondary mode transmits any read with one beep each.
// RL10 - The click mode no-scan timeout is configurable and returns to primary on expiry.
// RL11 - Hold mode runs the secondary pattern while the button is held and scans then.
// RL12 - Hold mode with gate on transmits the captured code on release with one beep.
// RL13 - Hold mode accepts repeated hold, scan and release cycles, one code each.
// RL14 - Hold mode returns to primary once released and no code is in the field.
// RL15 - At power up blue turns on while one beep sounds and white flashes.
// RL16 - Hold mode with gate off transmits reads while held, one beep each.
// RL17 - The button is debounced and a double click is two clicks within an interval.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module spbm_ctrl
#(
   // Clock cycles per millisecond tick
   parameter int unsigned TICK = spbm_pkg::TICK_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Button pin and decode path
   input wire logic btn_pin,
   input wire logic code_read,
   input wire logic code_present,
   // Scanner outputs
   output logic [1:0] pattern,
   output logic sec_mode,
   output logic xmit,
   output logic beep,
   output logic led_blue,
   output logic led_white
);
   // Button filter and its event bundle
   spbm_btn_if bi();
   spbm_btn_filter #(.TICK(TICK)) u_filt (
      .core_clk(core_clk),
      .rst(rst),
      .btn_pin(btn_pin),
      .bi(bi)
   );
   logic [31:0] cfg_r;
   logic [15:0] noscan_r, dclick_r, nsc_r;
   logic [7:0] beep_cnt_r;
   logic wr_pend_r, rd_pend_r;
   logic [7:0] a_r;
   logic held_code_r, armed_r, boot_r;
   spbm_pkg::spbm_state_t st_r, st_nxt;
   logic hold_mode, gate_on, ok_ev;
   // Tick divider is 17 bits wide and needs at least two cycles per tick
   if (TICK < 2 || TICK > 32'h0002_0000)
      $error("TICK out of range");
   // Configuration fields
   assign hold_mode = cfg_r[spbm_pkg::CFG_HOLD_BIT];
   assign gate_on = cfg_r[spbm_pkg::CFG_GATE_BIT];
   assign bi.dclick_ms = dclick_r;
   // Bus address phase capture; always zero wait states, OKAY
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         a_r <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else if (hready)
      begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         rd_pend_r <= hsel && htrans[1] && !hwrite;
         a_r <= haddr[7:0];
      end
   end
   // Register writes
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cfg_r <= spbm_pkg::CFG_RST; // [RL6]
         noscan_r <= spbm_pkg::NOSCAN_RST;
         dclick_r <= spbm_pkg::DCLICK_RST;
      end
      else if (wr_pend_r)
      begin
         if (a_r == spbm_pkg::CFG_OFS)
            cfg_r <= {24'h000000, hwdata[7:0]};
         else if (a_r == spbm_pkg::TIME_OFS)
         begin
            noscan_r <= hwdata[15:0]; // [RL10]
            dclick_r <= hwdata[31:16];
         end
      end
   end
   // Read data, registered at address phase
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         if (haddr[7:0] == spbm_pkg::CFG_OFS)
            hrdata <= cfg_r;
         else if (haddr[7:0] == spbm_pkg::TIME_OFS)
            hrdata <= {dclick_r, noscan_r};
         else if (haddr[7:0] == spbm_pkg::STAT_OFS)
            hrdata <= {26'h0000000, armed_r, held_code_r, 2'(st_r), pattern};
         else
            hrdata <= 32'h0000_0000;
      end
   end
   // Mode state machine
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         spbm_pkg::SPBM_ST_PRI:
         begin
            if (!hold_mode && bi.release_ev)
               st_nxt = spbm_pkg::SPBM_ST_SEC; // [RL2] [RL7]
            else if (hold_mode && bi.press)
               st_nxt = spbm_pkg::SPBM_ST_SEC; // [RL2] [RL11]
         end
         spbm_pkg::SPBM_ST_SEC:
         begin
            if (!hold_mode && bi.dclick)
               st_nxt = spbm_pkg::SPBM_ST_PRI; // [RL3]
            else if (!hold_mode && bi.tick && nsc_r >= noscan_r)
               st_nxt = spbm_pkg::SPBM_ST_PRI; // [RL3] [RL10]
            else if (hold_mode && bi.release_ev)
               st_nxt = spbm_pkg::SPBM_ST_HREL;
         end
         spbm_pkg::SPBM_ST_HREL:
         begin
            if (bi.press)
               st_nxt = spbm_pkg::SPBM_ST_SEC; // [RL13]
            else if (!code_present)
               st_nxt = spbm_pkg::SPBM_ST_PRI; // [RL14]
         end
         default: st_nxt = spbm_pkg::SPBM_ST_PRI;
      endcase
   end
   // State register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         st_r <= spbm_pkg::SPBM_ST_PRI; // [RL1]
      else
         st_r <= st_nxt;
   end
   // No-scan timer, counts milliseconds in secondary click mode
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         nsc_r <= 16'h0000;
      else if (st_r != spbm_pkg::SPBM_ST_SEC || code_read)
         nsc_r <= 16'h0000; // [RL10]
      else if (bi.tick && nsc_r != 16'hFFFF)
         nsc_r <= nsc_r + 16'h0001;
   end
   // Gate arming: a click in click mode allows one decode; hold capture latched
   // A new click or read in the same cycle as a transmit wins over the clear
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         armed_r <= 1'b0;
         held_code_r <= 1'b0;
      end
      else
      begin
         if (st_r != spbm_pkg::SPBM_ST_SEC)
            armed_r <= 1'b0;
         else if (!hold_mode && bi.release_ev && !bi.dclick)
            armed_r <= 1'b1; // [RL8]
         else if (ok_ev)
            armed_r <= 1'b0;
         if (st_r == spbm_pkg::SPBM_ST_PRI)
            held_code_r <= 1'b0;
         else if (st_r == spbm_pkg::SPBM_ST_SEC && code_read)
            held_code_r <= 1'b1; // [RL11]
         else if (ok_ev || (bi.press && hold_mode))
            held_code_r <= 1'b0;
      end
   end
   // Transmit decision per mode
   always_comb
   begin
      ok_ev = 1'b0;
      if (st_r == spbm_pkg::SPBM_ST_PRI)
         ok_ev = code_read; // [RL5]
      else if (!gate_on)
         ok_ev = code_read && st_r == spbm_pkg::SPBM_ST_SEC; // [RL9] [RL16]
      else if (!hold_mode)
         ok_ev = armed_r && code_read && st_r == spbm_pkg::SPBM_ST_SEC; // [RL8]
      else
         ok_ev = bi.release_ev && held_code_r; // [RL12] [RL13]
   end
   // Pattern, transmit pulse and mode flag
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         pattern <= 2'b00;
         sec_mode <= 1'b0;
         xmit <= 1'b0;
      end
      else
      begin
         pattern <= (st_nxt == spbm_pkg::SPBM_ST_PRI) ?
            cfg_r[spbm_pkg::CFG_PRI_LSB +: 2] : cfg_r[spbm_pkg::CFG_SEC_LSB +: 2]; // [RL4]
         sec_mode <= st_nxt != spbm_pkg::SPBM_ST_PRI;
         xmit <= ok_ev;
      end
   end
   // Beep and white flash; power-up beep then one per transmit
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         boot_r <= 1'b1;
         beep_cnt_r <= 8'h00;
         beep <= 1'b0;
         led_white <= 1'b0;
         led_blue <= 1'b0;
      end
      else
      begin
         led_blue <= 1'b1; // [RL15]
         if (boot_r || ok_ev)
         begin
            boot_r <= 1'b0;
            beep_cnt_r <= 8'(spbm_pkg::BEEP_MS); // [RL15] [RL8]
            beep <= 1'b1;
            led_white <= 1'b1;
         end
         else if (beep_cnt_r != 8'h00)
         begin
            if (bi.tick)
               beep_cnt_r <= beep_cnt_r - 8'h01;
         end
         else
         begin
            beep <= 1'b0;
            led_white <= 1'b0;
         end
      end
   end
   // Mode, pattern and transmit checks
   primary_reset_a: assert property (@(posedge core_clk) disable iff (rst) // [RL1]
      $fell(rst) |-> !sec_mode)
      else $error("not primary after reset");
   click_enter_a: assert property (@(posedge core_clk) disable iff (rst) // [RL7]
      (st_r == spbm_pkg::SPBM_ST_PRI && !hold_mode && bi.release_ev) |=> sec_mode)
      else $error("click did not enter secondary");
   hold_enter_a: assert property (@(posedge core_clk) disable iff (rst) // [RL11]
      (st_r == spbm_pkg::SPBM_ST_PRI && hold_mode && bi.press) |=> sec_mode)
      else $error("press did not enter secondary");
   dclick_exit_a: assert property (@(posedge core_clk) disable iff (rst) // [RL3]
      (st_r == spbm_pkg::SPBM_ST_SEC && !hold_mode && bi.dclick) |=> !sec_mode)
      else $error("double click did not exit");
   noscan_exit_a: assert property (@(posedge core_clk) disable iff (rst) // [RL10]
      (st_r == spbm_pkg::SPBM_ST_SEC && !hold_mode && bi.tick && nsc_r >= noscan_r)
      |=> !sec_mode) else $error("no-scan timeout did not exit");
   gate_click_a: assert property (@(posedge core_clk) disable iff (rst) // [RL8]
      (st_r == spbm_pkg::SPBM_ST_SEC && gate_on && !hold_mode && !armed_r) |=> !xmit)
      else $error("gated transmit without click");
   pri_xmit_a: assert property (@(posedge core_clk) disable iff (rst) // [RL5]
      (st_r == spbm_pkg::SPBM_ST_PRI && code_read) |=> xmit)
      else $error("primary read not sent");
   nogate_xmit_a: assert property (@(posedge core_clk) disable iff (rst) // [RL9]
      (st_r == spbm_pkg::SPBM_ST_SEC && !gate_on && code_read) |=> xmit && beep)
      else $error("ungated read not sent");
   hold_release_a: assert property (@(posedge core_clk) disable iff (rst) // [RL12]
      (st_r == spbm_pkg::SPBM_ST_SEC && hold_mode && gate_on && bi.release_ev && held_code_r)
      |=> xmit ##1 beep) else $error("hold release not sent");
   hold_again_a: assert property (@(posedge core_clk) disable iff (rst) // [RL13]
      (st_r == spbm_pkg::SPBM_ST_HREL && bi.press) |=> st_r == spbm_pkg::SPBM_ST_SEC)
      else $error("second hold not accepted");
   hold_return_a: assert property (@(posedge core_clk) disable iff (rst) // [RL14]
      (st_r == spbm_pkg::SPBM_ST_HREL && !bi.press && !code_present) |=> !sec_mode)
      else $error("hold mode did not return");
   pattern_sel_a: assert property (@(posedge core_clk) disable iff (rst) // [RL4]
      !sec_mode |-> pattern == $past(cfg_r[spbm_pkg::CFG_PRI_LSB +: 2]))
      else $error("wrong primary pattern");
   sec_pattern_a: assert property (@(posedge core_clk) disable iff (rst) // [RL4]
      sec_mode |-> pattern == $past(cfg_r[spbm_pkg::CFG_SEC_LSB +: 2]))
      else $error("wrong secondary pattern");
   beep_xmit_a: assert property (@(posedge core_clk) disable iff (rst) // [RL8]
      xmit |-> beep && led_white)
      else $error("transmit without beep");
   boot_beep_a: assert property (@(posedge core_clk) disable iff (rst) // [RL15]
      $fell(rst) |=> beep && led_white && led_blue)
      else $error("no power-up beep");
endmodule

/* test/spbm_op_model.sv */
// Operator button and decode path model for the scan controller.
// Assumes core_clk at 100 MHz; the bench calls its tasks right after a rising edge.
`timescale 1ns/1ns
module spbm_op_model
#(
   parameter int TICK = spbm_pkg::TICK_CYCLES
)
(
   // Clock
   input wire logic core_clk,
   // Button and decoder
   output logic btn_pin,
   output logic code_read,
   output logic code_present
);
   // Idle operator at time zero
   initial
   begin
      btn_pin = 1'b0;
      code_read = 1'b0;
      code_present = 1'b0;
   end
   // Hold the pin at one level for a number of milliseconds
   task automatic pin_ms(input logic v, input int ms);
      btn_pin <= v;
      repeat (ms * TICK) @(posedge core_clk);
   endtask
   // Full click, each level held past the debounce time
   task automatic click();
      pin_ms(1'b1, 22);
      pin_ms(1'b0, 22);
   endtask
   // Code enters the field; decoder flags it after a prompt or slow delay
   // Move a code into or out of the field, then let one edge pass
   task automatic field(input logic v);
      code_present <= v;
      @(posedge core_clk);
   endtask
   task automatic scan(input int dly);
      field(1'b1);
      repeat (dly) @(posedge core_clk);
      code_read <= 1'b1;
      @(posedge core_clk);
      code_read <= 1'b0;
   endtask
   // Code leaves the field
   task automatic leave();
      field(1'b0);
   endtask
endmodule

/* test/scan_pattern_button_mode_fsm_tb.sv */
// Self-checking bench for the scan pattern and button mode controller.
// Assumes the package, the controller top and the operator model are compiled first.
`timescale 1ns/1ns
module scan_pattern_button_mode_fsm_tb;
   // Shortened millisecond tick; the whole run takes about 4300 cycles
   localparam int TICK = 10;
   localparam int LIMIT = 20_000;
   logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, pattern, exp_st;
   logic [2:0] hsize;
   logic [7:0] cfg;
   logic btn_pin, code_read, code_present, sec_mode, xmit, beep, led_blue, led_white;
   int fail_count, cmp_count, cyc, xmit_seen, exp_xmit, i;
   // The one slave drives the bus ready
   assign hready = hreadyout;
   spbm_ctrl #(.TICK(TICK)) spbm_ctrl_inst (.core_clk(core_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .btn_pin(btn_pin),
      .code_read(code_read), .code_present(code_present), .pattern(pattern),
      .sec_mode(sec_mode), .xmit(xmit), .beep(beep), .led_blue(led_blue),
      .led_white(led_white));
   spbm_op_model #(.TICK(TICK)) spbm_op_model_inst (.core_clk(core_clk), .btn_pin(btn_pin),
      .code_read(code_read), .code_present(code_present));
   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Hang guard and transmit pulse counter
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (xmit === 1'b1)
         xmit_seen <= xmit_seen + 1;
      if (cyc == LIMIT)
      begin
         fail_count++;
         print_verdict();
      end
   end
   // Compare one value
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // One single word transfer; read data taken at the data phase edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic put_cfg(input logic [7:0] c);
      cfg = c;
      xfer(1'b1, 32'h0, {24'h0, c});
   endtask
   // Outputs and status word against the behavioural model
   task automatic cmp_state();
      logic [1:0] p;
      wait_cyc(3);
      p = (exp_st != 2'h0) ? cfg[7:6] : cfg[5:4];
      check(sec_mode, exp_st != 2'h0);
      check(pattern, p);
      check(xmit_seen, exp_xmit);
      check({hreadyout, hresp}, 2'h2);
      xfer(1'b0, 32'h8, 32'h0);
      check(rd[3:0], {exp_st, p});
   endtask
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      fail_count = 0;
      cmp_count = 0;
      cyc = 0;
      xmit_seen = 0;
      exp_xmit = 0;
      exp_st = 2'h0;
      cfg = 8'h42;
      void'($urandom(32'h7541));
      wait_cyc(12);
      check({hreadyout, hresp, led_blue}, 3'h4);
      rst <= 1'b0;
      @(posedge core_clk);
      #1;
      check({led_blue, beep, led_white}, 3'h7);
      cmp_state();
      xfer(1'b0, 32'h0, 32'h0);
      check(rd, 32'h42);
      xfer(1'b0, 32'h4, 32'h0);
      check(rd, 32'h0190_1388);
      xfer(1'b0, 32'hC, 32'h0);
      check(rd, 32'h0);
      xfer(1'b1, 32'h8, 32'hFFFF_FFFF);
      for (i = 0; i < 6; i++)
      begin
         put_cfg({2'($urandom % 3), 2'($urandom % 3), 4'h2});
         cmp_state();
      end
      // Click mode, gate on, secondary raster
      put_cfg(8'h82);
      xfer(1'b1, 32'h4, 32'h0032_03E8);
      spbm_op_model_inst.click();
      exp_st = 2'h1;
      cmp_state();
      spbm_op_model_inst.scan(2);
      cmp_state();
      spbm_op_model_inst.leave();
      wait_cyc(10 * TICK);
      spbm_op_model_inst.click();
      spbm_op_model_inst.scan(40);
      exp_xmit++;
      cmp_state();
      spbm_op_model_inst.leave();
      wait_cyc(10 * TICK);
      spbm_op_model_inst.click();
      spbm_op_model_inst.click();
      exp_st = 2'h0;
      cmp_state();
      // Primary reads always transmit, with a fresh beep
      wait_cyc(15 * TICK);
      check({beep, led_white}, 2'h0);
      spbm_op_model_inst.scan(1);
      exp_xmit++;
      cmp_state();
      check({beep, led_white}, 2'h3);
      spbm_op_model_inst.leave();
      spbm_op_model_inst.pin_ms(1'b1, 5);
      spbm_op_model_inst.pin_ms(1'b0, 16);
      cmp_state();
      // Click mode, gate off, then no-scan return
      put_cfg(8'h80);
      spbm_op_model_inst.click();
      exp_st = 2'h1;
      spbm_op_model_inst.scan(2);
      exp_xmit++;
      cmp_state();
      spbm_op_model_inst.leave();
      xfer(1'b1, 32'h4, 32'h0032_0002);
      wait_cyc(4 * TICK);
      exp_st = 2'h0;
      cmp_state();
      // Hold mode, gate on, two cycles; the second press comes while a code is still in view
      put_cfg(8'h43);
      for (i = 0; i < 2; i++)
      begin
         spbm_op_model_inst.pin_ms(1'b1, 22);
         exp_st = 2'h1;
         cmp_state();
         spbm_op_model_inst.scan(2);
         cmp_state();
         spbm_op_model_inst.pin_ms(1'b0, 22);
         exp_st = 2'h2;
         exp_xmit++;
         cmp_state();
      end
      spbm_op_model_inst.leave();
      exp_st = 2'h0;
      cmp_state();
      // Hold mode, gate off
      put_cfg(8'h41);
      spbm_op_model_inst.pin_ms(1'b1, 22);
      exp_st = 2'h1;
      spbm_op_model_inst.scan(2);
      exp_xmit++;
      cmp_state();
      spbm_op_model_inst.leave();
      spbm_op_model_inst.pin_ms(1'b0, 22);
      exp_st = 2'h0;
      cmp_state();
      print_verdict();
   end
endmodule
